// ---- logic/sfpe_flash_dev.sv ----
`timescale 1ns/100ps
module sfpe_flash_dev #(
  parameter int ADDR_W           = sfpe_pkg::MEM_ADDR_BITS,
  parameter int PROGRAM_CYC      = sfpe_pkg::PROGRAM_CYCLES,
  parameter int SECTOR_ERASE_CYC = sfpe_pkg::SECTOR_ERASE_CYCLES,
  parameter int HALF_BLOCK_CYC   = sfpe_pkg::HALF_BLOCK_ERASE_CYCLES,
  parameter int BLOCK_CYC        = sfpe_pkg::BLOCK_ERASE_CYCLES,
  parameter int WHOLE_ERASE_CYC  = sfpe_pkg::WHOLE_ERASE_CYCLES
) (
  sfpe_link_if.dev link,
  input  logic     clk,
  input  logic     sys_rst,
  input  logic     write_latch_flag,
  input  logic     quad_permit_bit,
  input  logic     protect_invert_bit,
  input  logic     protect_granule_bit,
  input  logic     protect_top_bottom_bit,
  input  logic     protect_range_bit2,
  input  logic     protect_range_bit1,
  input  logic     protect_range_bit0,
  output logic     busy,
  output logic     write_latch_clear
);
  import sfpe_pkg::*;

  localparam int MEM_BYTES = 1 << ADDR_W;

  // Link side, clocked by the serial clock
  typedef struct packed {
    logic [5:0]            hdr_cnt;
    logic [7:0]            opcode;
    logic [23:0]           addr;
    logic [7:0]            sh;
    logic [2:0]            dbit;
    logic [8:0]            nbytes;
    logic [7:0]            off;
    logic [PAGE_BYTES-1:0] mask;
    logic [7:0]            stat_sh;
    logic                  so;
  } sfpe_dev_link_t;

  // Core side, clocked by clk
  typedef struct packed {
    logic              cs_q;
    logic              busy;
    logic              wel_clr;
    sfpe_kind_t        kind;
    logic              walking;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W:0]   idx;
    logic [ADDR_W:0]   len;
    logic [31:0]       timer;
    logic [PAGE_BYTES-1:0] mask;
    logic              stat_busy;
  } sfpe_dev_core_t;

  sfpe_dev_link_t    rl;
  sfpe_dev_link_t    next_rl;
  sfpe_dev_link_t    base_l;
  logic              started;
  logic              so_oe;
  logic              next_so_oe;
  logic              frame_rst;
  logic [1:0]        stat_l;
  logic [7:0]        stat_byte;
  logic              quad_op;
  logic [3:0]        step;
  logic [3:0]        dsum;
  logic              buf_we;
  logic [7:0]        buf_wa;
  logic [7:0]        buf_wd;
  logic [7:0]        pbuf [PAGE_BYTES];

  sfpe_dev_core_t    r;
  sfpe_dev_core_t    next_r;
  logic              cs_s;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]        mem_wd;
  logic [7:0]        mem [MEM_BYTES];
  logic              fmt_ok;
  sfpe_kind_t        op_kind;
  int                span;
  int                cyc;
  int                op_lo;

  // ---------------- link domain ----------------
  sfpe_sync #(
    .W(2)
  ) u_stat_sync (
    .clk     (link.sclk),
    .sys_rst (sys_rst),
    .d       ({write_latch_flag, r.stat_busy}),
    .q       (stat_l)
  );

  assign frame_rst = sys_rst | link.cs_n;

  always_comb begin
    base_l = started ? rl : '0;
    next_rl = base_l;
    next_so_oe = so_oe;
    buf_we = 1'b0;
    buf_wa = base_l.off;
    buf_wd = '0;
    quad_op = base_l.opcode == OP_QUAD_PROGRAM;
    step = quad_op ? QUAD_STEP : SINGLE_STEP;
    dsum = {1'b0, base_l.dbit} + step;
    stat_byte = '0;
    stat_byte[STAT_BUSY_BIT] = stat_l[0];
    stat_byte[STAT_WEL_BIT] = stat_l[1];
    if (base_l.hdr_cnt < HDR_OPCODE_END) begin
      next_rl.opcode = {base_l.opcode[6:0], link.quad_line[0]};
      next_rl.hdr_cnt = base_l.hdr_cnt + 6'h01;
      if (next_rl.hdr_cnt == HDR_OPCODE_END && next_rl.opcode == OP_READ_STATUS) begin
        next_rl.so = stat_byte[7];
        next_rl.stat_sh = {stat_byte[6:0], stat_byte[7]};
        next_so_oe = 1'b1;
      end
    end else if (base_l.hdr_cnt < HDR_END) begin
      next_rl.addr = {base_l.addr[22:0], link.quad_line[0]};
      next_rl.hdr_cnt = base_l.hdr_cnt + 6'h01;
      next_rl.off = next_rl.addr[7:0];
    end else begin
      if (quad_op) begin
        next_rl.sh = {base_l.sh[3:0], link.quad_line};
      end else begin
        next_rl.sh = {base_l.sh[6:0], link.quad_line[0]};
      end
      next_rl.dbit = dsum[2:0];
      if (dsum[3]) begin
        buf_we = !stat_l[0];
        buf_wd = next_rl.sh;
        next_rl.mask[base_l.off] = 1'b1;
        next_rl.off = base_l.off + 8'h01;
        if (base_l.nbytes != NBYTES_MAX) begin
          next_rl.nbytes = base_l.nbytes + 9'h001;
        end
      end
    end
    if (base_l.hdr_cnt >= HDR_OPCODE_END && base_l.opcode == OP_READ_STATUS) begin
      next_rl.so = base_l.stat_sh[7];
      next_rl.stat_sh = {base_l.stat_sh[6:0], base_l.stat_sh[7]};
    end
  end

  always_ff @(posedge link.sclk or posedge sys_rst) begin
    if (sys_rst) begin
      rl <= '0;
    end else begin
      rl <= next_rl;
    end
  end

  // Frame start marker, cleared while select is high
  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      started <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      started <= 1'b1;
      so_oe <= next_so_oe;
    end
  end

  always_ff @(posedge link.sclk) begin
    if (buf_we) begin
      pbuf[buf_wa] <= buf_wd;
    end
  end

  assign link.dev_q_o = {2'b00, rl.so, 1'b0};
  assign link.dev_q_oe = {2'b00, so_oe, 1'b0};

  // ---------------- core domain ----------------
  sfpe_sync #(
    .W(1)
  ) u_cs_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (link.cs_n),
    .q       (cs_s)
  );

  function automatic logic prot_hit(input int lo_op, input int hi_op);
    int         size;
    int         lo;
    logic [2:0] bp;
    bp = {protect_range_bit2, protect_range_bit1, protect_range_bit0};
    size = 0;
    if (bp != 3'h0) begin
      size = protect_granule_bit ? (SECTOR_BYTES << (bp - 3'h1)) : (BLOCK_BYTES << (bp - 3'h1));
    end
    if (protect_granule_bit && size > HALF_BLOCK_BYTES) begin
      size = HALF_BLOCK_BYTES;
    end
    if (size > MEM_BYTES) begin
      size = MEM_BYTES;
    end
    lo = protect_top_bottom_bit ? 0 : MEM_BYTES - size;
    if (protect_invert_bit) begin
      return !(lo_op >= lo && hi_op <= lo + size);
    end
    return size != 0 && lo_op < lo + size && hi_op > lo;
  endfunction

  // Link state is quiet once the synced select rise is seen
  always_comb begin
    next_r = r;
    next_r.cs_q = cs_s;
    // Status busy trails busy, so a cleared latch shows first
    next_r.stat_busy = r.busy;
    next_r.wel_clr = 1'b0;
    mem_we = 1'b0;
    mem_wa = r.base + r.idx[ADDR_W-1:0];
    mem_wd = ERASED_BYTE;
    fmt_ok = 1'b0;
    op_kind = KIND_ERASE;
    span = PAGE_BYTES;
    cyc = PROGRAM_CYC;
    case (rl.opcode)
      OP_PROGRAM, OP_QUAD_PROGRAM: begin
        op_kind = KIND_PROGRAM;
        fmt_ok = rl.hdr_cnt == HDR_END && rl.nbytes != 9'h000 && rl.dbit == 3'h0 &&
                 (rl.opcode == OP_PROGRAM || quad_permit_bit);
      end
      OP_SECTOR_ERASE: begin
        span = SECTOR_BYTES;
        cyc = SECTOR_ERASE_CYC;
        fmt_ok = rl.hdr_cnt == HDR_END && rl.nbytes == 9'h000 && rl.dbit == 3'h0;
      end
      OP_HALF_BLOCK_ERASE: begin
        span = HALF_BLOCK_BYTES;
        cyc = HALF_BLOCK_CYC;
        fmt_ok = rl.hdr_cnt == HDR_END && rl.nbytes == 9'h000 && rl.dbit == 3'h0;
      end
      OP_BLOCK_ERASE: begin
        span = BLOCK_BYTES;
        cyc = BLOCK_CYC;
        fmt_ok = rl.hdr_cnt == HDR_END && rl.nbytes == 9'h000 && rl.dbit == 3'h0;
      end
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
        span = MEM_BYTES;
        cyc = WHOLE_ERASE_CYC;
        fmt_ok = rl.hdr_cnt == HDR_OPCODE_END;
      end
      default: begin
        fmt_ok = 1'b0;
      end
    endcase
    op_lo = (int'(rl.addr) & (MEM_BYTES - 1)) & ~(span - 1);
    // Anything refused leaves busy, latch and memory alone
    if (!r.cs_q && cs_s && !r.busy && fmt_ok && write_latch_flag &&
        !prot_hit(op_lo, op_lo + span)) begin
      next_r.busy = 1'b1;
      next_r.kind = op_kind;
      next_r.base = op_lo[ADDR_W-1:0];
      next_r.idx = '0;
      next_r.len = (ADDR_W+1)'(span);
      next_r.walking = 1'b1;
      next_r.mask = rl.mask;
      next_r.timer = 32'(cyc - 1);
    end
    if (r.busy) begin
      if (r.timer != 32'h0) begin
        next_r.timer = r.timer - 32'h1;
      end
      if (r.walking) begin
        if (r.kind == KIND_PROGRAM) begin
          mem_we = r.mask[r.idx[7:0]];
          mem_wd = mem[mem_wa] & pbuf[r.idx[7:0]];
        end else begin
          mem_we = 1'b1;
        end
        next_r.idx = r.idx + 1'b1;
        if (next_r.idx == r.len) begin
          next_r.walking = 1'b0;
        end
      end else if (r.timer == 32'h0) begin
        next_r.busy = 1'b0;
        next_r.wel_clr = r.kind == KIND_ERASE;
        next_r.kind = KIND_IDLE;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign busy = r.busy;
  assign write_latch_clear = r.wel_clr;
endmodule // sfpe_flash_dev

// ---- logic/sfpe_flash_host.sv ----
`timescale 1ns/100ps
module sfpe_flash_host #(
  parameter int HALF_DIV = sfpe_pkg::SCLK_HALF_CYCLES,
  parameter int GAP      = sfpe_pkg::FRAME_GAP_CYCLES
) (
  sfpe_link_if.host  link,
  input  logic       clk,
  input  logic       sys_rst,
  input  logic       cmd_valid,
  output logic       cmd_ready,
  input  logic [7:0] cmd_opcode,
  input  logic [23:0] cmd_addr,
  input  logic [8:0] cmd_len,
  input  logic       data_valid,
  input  logic [7:0] data_byte,
  output logic       data_ready,
  output logic       done,
  output logic [7:0] done_status
);
  import sfpe_pkg::*;

  typedef struct packed {
    sfpe_host_state_t st;
    logic [7:0]       opcode;
    logic [23:0]      addr;
    logic [1:0]       addr_left;
    logic [8:0]       data_left;
    logic             rd_left;
    logic             poll;
    logic             quad;
    logic [7:0]       sh;
    logic [3:0]       clk_left;
    logic [7:0]       div;
    logic             sclk;
    logic             cs_n;
    logic [3:0]       q_o;
    logic [3:0]       q_oe;
    logic [7:0]       rx;
    logic             cmd_ready;
    logic             data_ready;
    logic             done;
    logic [7:0]       status;
  } sfpe_host_reg_t;

  localparam sfpe_host_reg_t HOST_INIT = '{st: H_IDLE, cs_n: 1'b1, default: '0};

  sfpe_host_reg_t r;
  sfpe_host_reg_t next_r;
  logic           so_s;
  logic           is_prog;
  logic           is_erase;

  sfpe_sync #(
    .W(1)
  ) u_so_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (link.quad_line[1]),
    .q       (so_s)
  );

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    is_prog = r.opcode == OP_PROGRAM || r.opcode == OP_QUAD_PROGRAM;
    is_erase = r.opcode == OP_SECTOR_ERASE || r.opcode == OP_HALF_BLOCK_ERASE ||
               r.opcode == OP_BLOCK_ERASE || r.opcode == OP_CHIP_ERASE_A || r.opcode == OP_CHIP_ERASE_B;
    case (r.st)
      H_IDLE: begin
        next_r.cmd_ready = 1'b1;
        if (cmd_valid && r.cmd_ready) begin
          next_r.cmd_ready = 1'b0;
          next_r.opcode = cmd_opcode;
          next_r.addr = cmd_addr;
          next_r.cs_n = 1'b0;
          next_r.sh = cmd_opcode;
          next_r.clk_left = BYTE_CLOCKS;
          next_r.quad = 1'b0;
          next_r.poll = 1'b0;
          next_r.rd_left = cmd_opcode == OP_READ_STATUS;
          next_r.addr_left = (cmd_opcode == OP_CHIP_ERASE_A || cmd_opcode == OP_CHIP_ERASE_B ||
                              cmd_opcode == OP_READ_STATUS) ? 2'h0 : ADDR_BYTES;
          next_r.data_left = (cmd_opcode == OP_PROGRAM || cmd_opcode == OP_QUAD_PROGRAM) ? cmd_len : 9'h000;
          next_r.div = 8'(HALF_DIV - 1);
          next_r.st = H_LOW;
        end
      end
      H_LOW: begin
        next_r.q_o = r.quad ? r.sh[7:4] : {3'b000, r.sh[7]};
        next_r.q_oe = r.quad ? 4'hf : 4'h1;
        if (r.div != 8'h00) begin
          next_r.div = r.div - 8'h01;
        end else begin
          next_r.sclk = 1'b1;
          next_r.rx = {r.rx[6:0], so_s};
          next_r.div = 8'(HALF_DIV - 1);
          next_r.st = H_HIGH;
        end
      end
      H_HIGH: begin
        if (r.div != 8'h00) begin
          next_r.div = r.div - 8'h01;
        end else begin
          next_r.sclk = 1'b0;
          next_r.div = 8'(HALF_DIV - 1);
          next_r.sh = r.quad ? {r.sh[3:0], 4'h0} : {r.sh[6:0], 1'b0};
          next_r.clk_left = r.clk_left - 4'h1;
          next_r.st = H_LOW;
          if (r.clk_left == 4'h1) begin
            if (r.addr_left != 2'h0) begin
              next_r.sh = r.addr[23:16];
              next_r.addr = {r.addr[15:0], 8'h00};
              next_r.addr_left = r.addr_left - 2'h1;
              next_r.clk_left = BYTE_CLOCKS;
            end else if (r.data_left != 9'h000) begin
              next_r.data_ready = 1'b1;
              next_r.st = H_WANT;
            end else if (r.rd_left) begin
              next_r.rd_left = 1'b0;
              next_r.sh = 8'h00;
              next_r.clk_left = BYTE_CLOCKS;
            end else begin
              next_r.cs_n = 1'b1;
              next_r.q_oe = 4'h0;
              next_r.div = 8'(GAP - 1);
              next_r.st = H_END;
            end
          end
        end
      end
      H_WANT: begin
        if (data_valid && r.data_ready) begin
          next_r.data_ready = 1'b0;
          next_r.sh = data_byte;
          next_r.data_left = r.data_left - 9'h001;
          next_r.quad = r.opcode == OP_QUAD_PROGRAM;
          next_r.clk_left = (r.opcode == OP_QUAD_PROGRAM) ? QUAD_CLOCKS : BYTE_CLOCKS;
          next_r.st = H_LOW;
        end
      end
      H_END: begin
        if (r.div != 8'h00) begin
          next_r.div = r.div - 8'h01;
        end else if ((r.poll && r.rx[STAT_BUSY_BIT]) || (!r.poll && (is_prog || is_erase))) begin
          next_r.status = r.rx;
          next_r.poll = 1'b1;
          next_r.cs_n = 1'b0;
          next_r.sh = OP_READ_STATUS;
          next_r.clk_left = BYTE_CLOCKS;
          next_r.rd_left = 1'b1;
          next_r.quad = 1'b0;
          next_r.div = 8'(HALF_DIV - 1);
          next_r.st = H_LOW;
        end else begin
          next_r.status = r.rx;
          next_r.done = 1'b1;
          next_r.st = H_IDLE;
        end
      end
      default: begin
        next_r = HOST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= HOST_INIT;
    end else begin
      r <= next_r;
    end
  end

  assign link.cs_n = r.cs_n;
  assign link.sclk = r.sclk;
  assign link.host_q_o = r.q_o;
  assign link.host_q_oe = r.q_oe;
  assign cmd_ready = r.cmd_ready;
  assign data_ready = r.data_ready;
  assign done = r.done;
  assign done_status = r.status;
endmodule // sfpe_flash_host

// ---- logic/sfpe_link_if.sv ----
`timescale 1ns/100ps
interface sfpe_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_q_o;
  logic [3:0] host_q_oe;
  logic [3:0] dev_q_o;
  logic [3:0] dev_q_oe;
  logic [3:0] quad_line;

  // Undriven lines float high
  assign quad_line = (host_q_oe & host_q_o) | (~host_q_oe & dev_q_oe & dev_q_o) | (~host_q_oe & ~dev_q_oe);

  modport host (output cs_n, output sclk, output host_q_o, output host_q_oe, input quad_line);
  modport dev (input cs_n, input sclk, input quad_line, output dev_q_o, output dev_q_oe);
endinterface

// ---- logic/sfpe_pkg.sv ----
package sfpe_pkg;
  localparam logic [7:0] OP_PROGRAM          = 8'h02;
  localparam logic [7:0] OP_QUAD_PROGRAM     = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE     = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE      = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A     = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B     = 8'h60;
  localparam logic [7:0] OP_READ_STATUS      = 8'h05;
  localparam logic [7:0] ERASED_BYTE         = 8'hff;

  localparam logic [5:0] HDR_OPCODE_END = 6'h08;
  localparam logic [5:0] HDR_END        = 6'h20;
  localparam logic [3:0] SINGLE_STEP    = 4'h1;
  localparam logic [3:0] QUAD_STEP      = 4'h4;
  localparam logic [3:0] BYTE_CLOCKS    = 4'h8;
  localparam logic [3:0] QUAD_CLOCKS    = 4'h2;
  localparam logic [1:0] ADDR_BYTES     = 2'h3;
  localparam logic [8:0] NBYTES_MAX     = 9'h100;

  localparam int PAGE_BYTES       = 256;
  localparam int SECTOR_BYTES     = 4096;
  localparam int HALF_BLOCK_BYTES = 32768;
  localparam int BLOCK_BYTES      = 65536;
  localparam int MEM_ADDR_BITS    = 20;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WEL_BIT  = 1;

  localparam int CLK_MHZ                    = 20;
  localparam int PROGRAM_CYCLE_TIME_US      = 700;
  localparam int SECTOR_ERASE_TIME_US       = 60000;
  localparam int HALF_BLOCK_ERASE_TIME_US   = 120000;
  localparam int BLOCK_ERASE_TIME_US        = 150000;
  localparam int WHOLE_ERASE_TIME_US        = 3000000;
  localparam int PROGRAM_CYCLES             = PROGRAM_CYCLE_TIME_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYCLES        = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int HALF_BLOCK_ERASE_CYCLES    = HALF_BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int BLOCK_ERASE_CYCLES         = BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int WHOLE_ERASE_CYCLES         = WHOLE_ERASE_TIME_US * CLK_MHZ;

  localparam int SCLK_HALF_CYCLES = 4;
  localparam int FRAME_GAP_CYCLES = 8;

  typedef enum logic [1:0] {
    KIND_IDLE    = 2'b00,
    KIND_PROGRAM = 2'b01,
    KIND_ERASE   = 2'b10
  } sfpe_kind_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOW  = 3'b001,
    H_HIGH = 3'b010,
    H_WANT = 3'b011,
    H_END  = 3'b100
  } sfpe_host_state_t;
endpackage

// ---- logic/sfpe_sync.sv ----
`timescale 1ns/100ps
module sfpe_sync #(
  parameter int W = 1
) (
  input  logic         clk,
  input  logic         sys_rst,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sfpe_sync_t;

  sfpe_sync_t r;
  sfpe_sync_t next_r;

  always_comb begin
    next_r.meta   = d;
    next_r.stable = r.meta;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.stable;
endmodule // sfpe_sync

// ---- testbench/serial_flash_program_erase_test.sv ----
`timescale 1ns/100ps
module serial_flash_program_erase_test;
  import sfpe_pkg::*;
  localparam int CYC = 300;
  logic        clk = 0;
  logic        sys_rst = 0;
  logic        cmd_valid = 0;
  logic        data_valid = 0;
  logic        write_latch_flag = 0;
  logic        quad_permit_bit = 0;
  logic        tk = 0;
  logic        busy_q = 0;
  logic [5:0]  pv = 0;
  logic [7:0]  cmd_opcode = 0;
  logic [7:0]  data_byte = 0;
  logic [23:0] cmd_addr = 0;
  logic [8:0]  cmd_len = 0;
  logic        cmd_ready, data_ready, done, busy, write_latch_clear;
  logic [7:0]  done_status;
  logic [7:0]  tx [0:511];
  logic [7:0]  em [0:65535];
  int          tx_n = 0, di = 0, busy_n = 0, wlc_n = 0, miscompares = 0, check_count = 0;

  sfpe_link_if link();
  sfpe_flash_host sfpe_flash_host_i (.link(link), .clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_opcode, .cmd_addr,
    .cmd_len, .data_valid, .data_byte, .data_ready, .done, .done_status);
  sfpe_flash_dev #(.ADDR_W(16), .PROGRAM_CYC(CYC), .SECTOR_ERASE_CYC(CYC), .HALF_BLOCK_CYC(CYC), .BLOCK_CYC(CYC),
    .WHOLE_ERASE_CYC(CYC)) sfpe_flash_dev_i (.link(link), .clk, .sys_rst, .write_latch_flag, .quad_permit_bit,
    .protect_invert_bit(pv[5]), .protect_granule_bit(pv[4]), .protect_top_bottom_bit(pv[3]),
    .protect_range_bit2(pv[2]), .protect_range_bit1(pv[1]), .protect_range_bit0(pv[0]), .busy, .write_latch_clear);
  sfpe_link_sva #(.MIN_BUSY(CYC - 4)) sfpe_link_sva_i (.clk, .sys_rst, .cs_n(link.cs_n), .sclk(link.sclk),
    .dev_q_oe(link.dev_q_oe), .busy, .write_latch_clear, .write_latch_flag);

  initial forever #25 clk = ~clk;

  // Data bytes handed over one per handshake, one idle cycle between
  always @(posedge clk) begin
    tk <= data_valid && data_ready;
    if (data_valid && data_ready) di <= di + 1;
  end
  always @(negedge clk) begin
    data_valid <= data_ready === 1'b1 && !tk && di < tx_n;
    data_byte  <= tx[di];
    if (busy === 1'b1 && busy_q !== 1'b1) busy_n++;
    busy_q = busy;
    if (write_latch_clear === 1'b1) begin
      wlc_n++;
      write_latch_flag <= 1'b0;
    end
  end

  function automatic logic [15:0] wrap_at(logic [15:0] a, int i);
    return {a[15:8], 8'(a[7:0] + i)};
  endfunction
  function automatic logic [7:0] exp_status(logic l);
    return {6'h00, l, 1'b0};
  endfunction

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_page(input logic [7:0] pg);
    for (int j = 0; j < 256; j++) check_byte(sfpe_flash_dev_i.mem[{pg, 8'(j)}], em[{pg, 8'(j)}]);
  endtask
  task automatic put(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++) em[wrap_at(a, i)] = tx[i];
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic run(input logic [7:0] op, input logic [23:0] a, input int n, input logic l, input logic q,
                     input logic [5:0] p);
    int t;
    @(negedge clk);
    write_latch_flag = l;
    quad_permit_bit = q;
    pv = p;
    di = 0;
    tx_n = n;
    cmd_opcode = op;
    cmd_addr = a;
    cmd_len = 9'(n);
    cmd_valid = 1;
    t = 0;
    while (cmd_ready !== 1'b1 && t < 100) begin
      @(negedge clk);
      t++;
    end
    @(negedge clk);
    cmd_valid = 0;
    while (done !== 1'b1 && t < 200000) begin
      @(negedge clk);
      t++;
    end
    if (t >= 200000) miscompares++;
    check_byte(done_status, exp_status(write_latch_flag));
  endtask

  initial begin
    logic [15:0] a;
    logic [7:0]  rop [0:5];
    int          n, b;
    n = $urandom(90);
    #1 sys_rst = 1;
    repeat (5) @(posedge clk);
    @(negedge clk) sys_rst = 0;
    for (int i = 0; i < 65536; i++) em[i] = ERASED_BYTE;
    run(OP_CHIP_ERASE_A, 24'h0, 0, 1, 0, 6'h00);
    check_bit(write_latch_flag, 1'b0);
    for (int i = 0; i < 4; i++) check_page(8'($urandom));
    $display("test chip erase done");
    for (int i = 1; i < 8; i++) begin
      a = {8'(i), (i == 1) ? 8'hfc : 8'($urandom)};
      n = (i == 1) ? 8 : 1 + $urandom % 12;
      for (int j = 0; j < n; j++) tx[j] = 8'($urandom);
      run(i[0] ? OP_PROGRAM : OP_QUAD_PROGRAM, {8'h00, a}, n, 1, 1, 6'h00);
      put(a, n);
      check_page(8'(i));
    end
    check_byte(8'(busy_n), 8'h08);
    for (int j = 0; j < 260; j++) tx[j] = 8'($urandom);
    run(OP_QUAD_PROGRAM, 24'h002000, 260, 1, 1, 6'h00);
    put(16'h2000, 260);
    check_page(8'h20);
    $display("test program done");
    run(OP_SECTOR_ERASE, 24'h000abc, 0, 1, 0, 6'h00);
    for (int i = 0; i < 4096; i++) em[i] = ERASED_BYTE;
    check_page(8'h01);
    check_page(8'h20);
    check_byte(8'(wlc_n), 8'h02);
    $display("test sector erase done");
    rop = '{OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE_B, OP_PROGRAM, OP_SECTOR_ERASE, OP_QUAD_PROGRAM};
    b = busy_n;
    for (int k = 0; k < 6; k++) begin
      run(rop[k], 24'h002010, 4, k != 4, k != 5,
          k < 3 ? {2'b00, 1'($urandom), 3'(1 + $urandom % 7)} : {k == 3, 5'h00});
    end
    check_page(8'h20);
    check_byte(8'(busy_n), 8'(b));
    $display("test refusals done");
    complete_run;
  end

  initial begin
    #(150000 * 50);
    miscompares++;
    complete_run;
  end
endmodule // serial_flash_program_erase_test

// ---- testbench/sfpe_link_sva.sv ----
`timescale 1ns/100ps
module sfpe_link_sva #(
  parameter int MIN_BUSY = 296
) (
  input logic       clk,
  input logic       sys_rst,
  input logic       cs_n,
  input logic       sclk,
  input logic [3:0] dev_q_oe,
  input logic       busy,
  input logic       write_latch_clear,
  input logic       write_latch_flag
);
  logic [16:0] busy_len;
  logic [11:0] bit_cnt;
  logic [3:0]  hi_cnt;
  logic        sclk_q;
  logic        cs_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_len <= '0;
      bit_cnt  <= '0;
      hi_cnt   <= '0;
      sclk_q   <= 1'b0;
      cs_q     <= 1'b1;
    end else begin
      sclk_q   <= sclk;
      cs_q     <= cs_n;
      busy_len <= busy ? busy_len + 17'h1 : 17'h0;
      hi_cnt   <= !cs_n ? 4'h0 : (hi_cnt == 4'hf ? hi_cnt : hi_cnt + 4'h1);
      if (cs_n && cs_q) begin
        bit_cnt <= '0;
      end else if (sclk && !sclk_q) begin
        bit_cnt <= bit_cnt + 12'h1;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence sel_release;  $rose(cs_n); endsequence
  sequence cycle_launch; $rose(busy); endsequence
  sequence cycle_end;    $fell(busy); endsequence

  chk_launch_after_release: assert property (cycle_launch |-> cs_n && hi_cnt >= 4'h2 && hi_cnt <= 4'h6)
    else $error("busy rose out of step with select");
  chk_cycle_min_length: assert property (cycle_end |-> busy_len >= MIN_BUSY)
    else $error("timed cycle too short");
  chk_cycle_bounded: assert property (busy |-> busy_len < 17'h12000)
    else $error("timed cycle never ends");
  chk_launch_needs_latch: assert property (cycle_launch |-> write_latch_flag)
    else $error("cycle started with write latch low");
  chk_clear_at_end: assert property (write_latch_clear |-> cycle_end)
    else $error("latch clear away from cycle end");
  chk_clear_single_pulse: assert property (write_latch_clear |=> !write_latch_clear)
    else $error("latch clear longer than one cycle");
  chk_release_on_byte: assert property (sel_release |-> bit_cnt >= 12'h8 && !bit_cnt[0])
    else $error("select released off a unit boundary");
  chk_clock_still: assert property (cs_n && cs_q |-> !sclk)
    else $error("serial clock moves outside a frame");
  chk_status_line_only: assert property (dev_q_oe[3:2] == 2'b00 && !dev_q_oe[0])
    else $error("device drives a line other than status out");
endmodule // sfpe_link_sva
